/* verilog/reset_clock_defines.vh */
// constants for the reset and clock control block
// assumes inclusion by bare name from verilog/ sources
`ifndef RESET_CLOCK_DEFINES_VH
`define RESET_CLOCK_DEFINES_VH

// processor clock source codes
`define CPU_SRC_XTAL 2'h0
`define CPU_SRC_FOSC 2'h1
`define CPU_SRC_PLL 2'h2
// processor divider: value n divides by 2n, zero leaves it undivided
`define CPU_DIV_W 8
`define CPU_DIV_RESET 8'h01
`define CPU_DIV_OFF 8'h00
// select code that writes ignore, for both source selects
`define SRC_CODE_RSVD 2'h3
// always-on fast divider value after system reset
`define FAST_DIV_RESET 8'h00
// toggle on every rising crystal edge gives crystal divided by 2
`define XTAL_D2_HALF 8'h00
// slow clock source codes
`define SLOW_SRC_XTAL32K 2'h0
`define SLOW_SRC_SOSC 2'h1
`define SLOW_SRC_FOSC_D256 2'h2
// fast rc divided by 256 for the slow clock: toggle every 128 edges
`define FOSC_D256_HALF 8'h7f
// always-on fast clock source codes
`define FAST_SRC_XTAL_D2 1'h0
`define FAST_SRC_FOSC_DN 1'h1
// reset hold counter load; each pulse lasts this many system clock cycles plus one
`define RST_PULSE_LEN 4'h8
`define RST_CNT_W 4
// reset level encoding
`define LVL_NONE 3'h0
`define LVL_CPU 3'h1
`define LVL_CORE 3'h2
`define LVL_SYS 3'h3
`define LVL_CHIP 3'h4

`endif

/* verilog/clock_divider.v */
// divide-by-2(n+1) toggling clock divider with even duty
// assumes src_i is a free-running clock and div_i is quasi-static;
// reset only lands if src_i has an edge while rstn_i is low
`timescale 1ns/1ps
`include "reset_clock_defines.vh"

module clock_divider (
    input wire src_i,
    input wire rstn_i,
    input wire [7:0] div_i,
    output reg clk_o
);
    reg [7:0] cnt;

    // count reaches div_i then toggles; div 0 gives half of src
    always @(posedge src_i) begin
        if (!rstn_i) begin
            cnt <= 8'h00;
            clk_o <= 1'b0;
        end else if (cnt >= div_i) begin
            cnt <= 8'h00;
            clk_o <= ~clk_o;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // clock_divider

/* verilog/reset_and_clock_control.v */
// reset level generator and clock source selection
// assumes all request and select inputs are synchronous to clk_sys_i;
// clock muxes are plain combinational selects feeding flops, sources are
// assumed slow compared with a glitch-free mux in real silicon
//
// Behaviour
// - four reset levels: processor, core, system, whole chip, each requestable
// - only the whole-chip reset is flagged as losing memory contents
// - processor reset touches just the processor, then it restarts at reset vector
// - core reset covers all digital logic except the always-on domain
// - system reset covers all digital logic including the always-on domain
// - whole-chip reset returns every part of the chip to initial state
// - software writes request a reset, which is then asserted
// - hardware circuitry may request resets directly without software
// - processor clock from main crystal, fast rc or pll, software selected
// - processor clock undivided or through a software divider
// - after processor reset, selection returns to main crystal divided by two
// - slow clock from 32k crystal, slow rc, or fast rc divided by 256
// - always-on fast clock from crystal divided by 2 or fast rc divided by 2(n+1)
`timescale 1ns/1ps
`include "reset_clock_defines.vh"

module reset_and_clock_control (
    input wire clk_sys_i,
    input wire rstn_i,
    // clock sources
    input wire xtal_clk_i,
    input wire fosc_clk_i,
    input wire pll_clk_i,
    input wire xtal32k_clk_i,
    input wire sosc_clk_i,
    // software reset requests, one-cycle pulses
    input wire sw_cpu_rst_i,
    input wire sw_core_rst_i,
    input wire sw_sys_rst_i,
    input wire sw_chip_rst_i,
    // hardware reset requests, one-cycle pulses
    input wire hw_cpu_rst_i,
    input wire hw_core_rst_i,
    input wire hw_sys_rst_i,
    input wire hw_chip_rst_i,
    // software clock configuration
    input wire cpu_clk_cfg_we_i,
    input wire [1:0] cpu_src_sel_i,
    input wire cpu_div_en_i,
    input wire [7:0] cpu_div_i,
    input wire [1:0] slow_src_sel_i,
    input wire fast_src_sel_i,
    input wire [7:0] fast_div_n_i,
    // reset outputs active low; memory-loss flag active high, plus last level code
    output reg cpu_rst_n_o,
    output reg core_rst_n_o,
    output reg sys_rst_n_o,
    output reg chip_rst_n_o,
    output reg mem_lost_o,
    output reg [2:0] last_rst_lvl_o,
    // clock outputs and visible selections
    output reg cpu_clk_o,
    output reg [1:0] cpu_src_o,
    output reg cpu_div_en_o,
    output reg [7:0] cpu_div_o,
    output reg slow_clk_o,
    output reg fast_clk_o
);
    localparam ST_IDLE = 2'h0;
    localparam ST_HOLD = 2'h1;

    reg [1:0] state;
    reg [2:0] level;
    reg [3:0] cnt;
    reg [2:0] next_req;
    reg [1:0] slow_src;
    reg fast_src;
    reg [7:0] fast_div_n;

    // picks the broadest of four request bits
    function [2:0] broadest;
        input [3:0] r;
        begin
            if (r[3])
                broadest = `LVL_CHIP;
            else if (r[2])
                broadest = `LVL_SYS;
            else if (r[1])
                broadest = `LVL_CORE;
            else if (r[0])
                broadest = `LVL_CPU;
            else
                broadest = `LVL_NONE;
        end
    endfunction

    wire [3:0] req_vec = {sw_chip_rst_i | hw_chip_rst_i,
                          sw_sys_rst_i | hw_sys_rst_i,
                          sw_core_rst_i | hw_core_rst_i,
                          sw_cpu_rst_i | hw_cpu_rst_i};

    always @* begin
        next_req = broadest(req_vec);
    end

    // reset sequencer; a broader request during a hold widens the level
    always @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            state <= ST_HOLD;
            level <= `LVL_CHIP;
            cnt <= `RST_PULSE_LEN;
            last_rst_lvl_o <= `LVL_CHIP;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (next_req != `LVL_NONE) begin
                        state <= ST_HOLD;
                        level <= next_req;
                        cnt <= `RST_PULSE_LEN;
                        last_rst_lvl_o <= next_req;
                    end
                end
                ST_HOLD: begin
                    if (next_req > level) begin
                        level <= next_req;
                        cnt <= `RST_PULSE_LEN;
                        last_rst_lvl_o <= next_req;
                    end else if (cnt == 4'h0) begin
                        state <= ST_IDLE;
                        level <= `LVL_NONE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    level <= `LVL_NONE;
                end
            endcase
        end
    end

    // nested outputs: broader level pulls every narrower one
    always @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            cpu_rst_n_o <= 1'b0;
            core_rst_n_o <= 1'b0;
            sys_rst_n_o <= 1'b0;
            chip_rst_n_o <= 1'b0;
            mem_lost_o <= 1'b1;
        end else begin
            cpu_rst_n_o <= ~(level >= `LVL_CPU);
            core_rst_n_o <= ~(level >= `LVL_CORE);
            sys_rst_n_o <= ~(level >= `LVL_SYS);
            chip_rst_n_o <= ~(level >= `LVL_CHIP);
            mem_lost_o <= (level == `LVL_CHIP);
        end
    end

    // processor clock config: lives in processor reset scope
    always @(posedge clk_sys_i) begin
        if (!rstn_i || !cpu_rst_n_o) begin
            cpu_src_o <= `CPU_SRC_XTAL;
            cpu_div_en_o <= 1'b1;
            cpu_div_o <= `CPU_DIV_RESET;
        end else if (cpu_clk_cfg_we_i) begin
            // reserved source code keeps the prior choice
            if (cpu_src_sel_i != `SRC_CODE_RSVD)
                cpu_src_o <= cpu_src_sel_i;
            cpu_div_en_o <= cpu_div_en_i;
            cpu_div_o <= cpu_div_i;
        end
    end

    // always-on selects survive core reset but not system reset
    always @(posedge clk_sys_i) begin
        if (!rstn_i || !sys_rst_n_o) begin
            slow_src <= `SLOW_SRC_XTAL32K;
            fast_src <= `FAST_SRC_XTAL_D2;
            fast_div_n <= `FAST_DIV_RESET;
        end else if (cpu_clk_cfg_we_i) begin
            if (slow_src_sel_i != `SRC_CODE_RSVD)
                slow_src <= slow_src_sel_i;
            fast_src <= fast_src_sel_i;
            fast_div_n <= fast_div_n_i;
        end
    end

    // divider value n divides by 2(n+1); cpu divider of 1 gives divide by 2
    wire xtal_d2;
    wire fosc_dn;
    wire fosc_d256;
    wire cpu_div_src;
    wire [7:0] cpu_div_half = cpu_div_o - 8'h01;

    reg cpu_src_clk;
    always @* begin
        case (cpu_src_o)
            `CPU_SRC_XTAL: cpu_src_clk = xtal_clk_i;
            `CPU_SRC_FOSC: cpu_src_clk = fosc_clk_i;
            `CPU_SRC_PLL: cpu_src_clk = pll_clk_i;
            default: cpu_src_clk = xtal_clk_i;
        endcase
    end

    // dividers are held through the chip-level hold, which is long enough for
    // a slow source to see an edge; a bare rstn_i pulse may pass between edges
    clock_divider u_cpu_div (
        .src_i(cpu_src_clk),
        .rstn_i(chip_rst_n_o),
        .div_i(cpu_div_half),
        .clk_o(cpu_div_src)
    );
    clock_divider u_xtal_d2 (
        .src_i(xtal_clk_i),
        .rstn_i(chip_rst_n_o),
        .div_i(`XTAL_D2_HALF),
        .clk_o(xtal_d2)
    );
    clock_divider u_fosc_dn (
        .src_i(fosc_clk_i),
        .rstn_i(chip_rst_n_o),
        .div_i(fast_div_n),
        .clk_o(fosc_dn)
    );
    clock_divider u_fosc_d256 (
        .src_i(fosc_clk_i),
        .rstn_i(chip_rst_n_o),
        .div_i(`FOSC_D256_HALF),
        .clk_o(fosc_d256)
    );

    // outputs retimed on the system clock; limits output rate to half of it
    always @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            cpu_clk_o <= 1'b0;
            slow_clk_o <= 1'b0;
            fast_clk_o <= 1'b0;
        end else begin
            cpu_clk_o <= (cpu_div_en_o && cpu_div_o != `CPU_DIV_OFF) ? cpu_div_src
                                                              : cpu_src_clk;
            case (slow_src)
                `SLOW_SRC_XTAL32K: slow_clk_o <= xtal32k_clk_i;
                `SLOW_SRC_SOSC: slow_clk_o <= sosc_clk_i;
                `SLOW_SRC_FOSC_D256: slow_clk_o <= fosc_d256;
                default: slow_clk_o <= xtal32k_clk_i;
            endcase
            fast_clk_o <= (fast_src == `FAST_SRC_FOSC_DN) ? fosc_dn : xtal_d2;
        end
    end
endmodule // reset_and_clock_control

/* tb/rcc_properties.sv */
// checker for reset nesting, hold length and processor clock config
// assumes binding onto reset_and_clock_control ports by name
`timescale 1ns/1ps
module rcc_properties (
    input wire clk_sys_i,
    input wire rstn_i,
    input wire sw_core_rst_i,
    input wire hw_sys_rst_i,
    input wire cpu_clk_cfg_we_i,
    input wire [1:0] cpu_src_sel_i,
    input wire cpu_rst_n_o,
    input wire core_rst_n_o,
    input wire sys_rst_n_o,
    input wire chip_rst_n_o,
    input wire mem_lost_o,
    input wire [1:0] cpu_src_o,
    input wire cpu_div_en_o,
    input wire [7:0] cpu_div_o
);
default clocking @(posedge clk_sys_i); endclocking
default disable iff (!rstn_i);
core_nest_a: assert property (!core_rst_n_o |-> !cpu_rst_n_o)
    else $error("core reset without cpu reset");
sys_nest_a: assert property (!sys_rst_n_o |-> !core_rst_n_o)
    else $error("system reset without core reset");
chip_nest_a: assert property (!chip_rst_n_o |-> !sys_rst_n_o)
    else $error("chip reset without system reset");
mem_flag_a: assert property (mem_lost_o |-> !chip_rst_n_o)
    else $error("memory loss flagged below chip level");
// cpu output high means no hold is running, so the request must land
sw_take_a: assert property (sw_core_rst_i && cpu_rst_n_o |-> ##2 !core_rst_n_o)
    else $error("software core request not applied");
hw_take_a: assert property (hw_sys_rst_i && cpu_rst_n_o |-> ##2 !sys_rst_n_o)
    else $error("hardware system request not applied");
hold_len_a: assert property ($fell(cpu_rst_n_o) |=> (!cpu_rst_n_o) [*8])
    else $error("reset pulse too short");
cpu_default_a: assert property ($rose(cpu_rst_n_o) |->
    cpu_src_o == 2'h0 && cpu_div_en_o && cpu_div_o == 8'h01) else $error("cpu clock not default");
cfg_load_a: assert property (cpu_clk_cfg_we_i && cpu_rst_n_o && cpu_src_sel_i != 2'h3
    |=> cpu_src_o == $past(cpu_src_sel_i)) else $error("cpu source not loaded");
cover property ($fell(chip_rst_n_o));
cover property ($fell(cpu_rst_n_o) && core_rst_n_o);
cover property (cpu_clk_cfg_we_i && cpu_src_sel_i == 2'h2);
endmodule // rcc_properties
bind reset_and_clock_control rcc_properties rcc_properties_i (.*);

/* tb/reset_and_clock_control_bench.sv */
// self-checking bench: reset levels, clock selection and division
// assumes sources made from a counter well below the system clock
`timescale 1ns/1ps
module reset_and_clock_control_bench;
reg clk_sys_i = 0, rstn_i = 0, we = 0, den = 1, fsel = 0, pv;
reg [5:0] cnt = 0;
reg [3:0] sw = 0, hw = 0;
reg [1:0] csel = 0, ssel = 0;
reg [7:0] dv = 1, fn = 0;
wire cr, kr, sr, hr, ml, cc, de, sc, fc;
wire [2:0] lv;
wire [1:0] cs;
wire [7:0] cd;
integer n_fail = 0, n_checks = 0, i, l, e, k;
reset_and_clock_control reset_and_clock_control_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .xtal_clk_i(cnt[3]), .fosc_clk_i(cnt[2]), .pll_clk_i(cnt[1]), .xtal32k_clk_i(cnt[5]),
    .sosc_clk_i(cnt[4]), .sw_cpu_rst_i(sw[0]), .sw_core_rst_i(sw[1]), .sw_sys_rst_i(sw[2]),
    .sw_chip_rst_i(sw[3]), .hw_cpu_rst_i(hw[0]), .hw_core_rst_i(hw[1]), .hw_sys_rst_i(hw[2]),
    .hw_chip_rst_i(hw[3]), .cpu_clk_cfg_we_i(we), .cpu_src_sel_i(csel), .cpu_div_en_i(den),
    .cpu_div_i(dv), .slow_src_sel_i(ssel), .fast_src_sel_i(fsel), .fast_div_n_i(fn),
    .cpu_rst_n_o(cr), .core_rst_n_o(kr), .sys_rst_n_o(sr), .chip_rst_n_o(hr), .mem_lost_o(ml),
    .last_rst_lvl_o(lv), .cpu_clk_o(cc), .cpu_src_o(cs), .cpu_div_en_o(de), .cpu_div_o(cd),
    .slow_clk_o(sc), .fast_clk_o(fc));
initial forever #5 clk_sys_i = ~clk_sys_i;
always @(negedge clk_sys_i) cnt <= cnt + 6'h01;
function [3:0] hi(input integer v);
    hi = ~((4'h1 << v) - 4'h1);
endfunction
function integer ex(input integer w, input integer h, input integer d);
    ex = w / (h * d);
endfunction
task report_and_stop; begin
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
end endtask
task chk(input ok, input [8*8-1:0] m); begin
    n_checks = n_checks + 1;
    if (ok !== 1'b1) begin
        n_fail = n_fail + 1;
        $display("Error at %0t: %0s", $time, m);
    end
end endtask
task settle; begin
    k = 0;
    repeat (3) @(negedge clk_sys_i);
    while (cr !== 1'b1 && k < 40) begin
        @(negedge clk_sys_i);
        k = k + 1;
    end
    if (cr !== 1'b1) begin
        chk(0, "hang");
        report_and_stop;
    end
end endtask
task req(input integer v, input h); begin
    if (h) hw[v-1] = 1;
    else sw[v-1] = 1;
    @(negedge clk_sys_i);
    sw = 0;
    hw = 0;
end endtask
task cfg(input [1:0] s, input en, input [7:0] d); begin
    csel = s;
    den = en;
    dv = d;
    we = 1;
    @(negedge clk_sys_i);
    we = 0;
    repeat (4) @(negedge clk_sys_i);
end endtask
// counts output toggles; retiming jitter allows one either way
task meas(input integer w, input integer sel, input integer x); begin
    k = 0;
    pv = {fc, sc, cc} >> sel;
    repeat (w) begin
        @(negedge clk_sys_i);
        if ((({fc, sc, cc} >> sel) & 3'h1) !== {2'h0, pv}) k = k + 1;
        pv = {fc, sc, cc} >> sel;
    end
    chk(k >= x - 1 && k <= x + 1, "freq");
end endtask
initial begin
    k = $urandom(32'hfa55_915e);
    repeat (5) @(negedge clk_sys_i);
    rstn_i = 1;
    settle;
    chk({hr, sr, kr} === 3'h7 && ml === 1'b0, "boot");
    for (i = 0; i < 24; i = i + 1) begin
        l = (i < 8) ? i % 4 + 1 : $urandom % 4 + 1;
        req(l, (i < 8) ? i / 4 : $urandom % 2);
        repeat (3) @(negedge clk_sys_i);
        e = l;
        if (i >= 8 && i % 2) begin
            k = $urandom % 4 + 1;
            req(k, 0);
            e = (k > l) ? k : l;
            repeat (3) @(negedge clk_sys_i);
        end
        chk({hr, sr, kr, cr} === hi(e), "levels");
        chk(lv === e[2:0] && ml === (e == 4), "lvl");
        settle;
        chk({hr, sr, kr, cr} === 4'hf && ml === 1'b0, "release");
    end
    cfg(2, 0, 0);
    chk(cs === 2'h2 && de === 1'b0, "cfg");
    meas(64, 0, ex(64, 2, 1));
    cfg(1, 1, 1);
    meas(128, 0, ex(128, 4, 2));
    cfg(0, 1, 2);
    meas(256, 0, ex(256, 8, 4));
    cfg(3, 0, 0);
    chk(cs === 2'h0, "refuse");
    cfg(2, 0, 0);
    req(1, 0);
    settle;
    chk(cs === 2'h0 && de === 1'b1 && cd === 8'h01, "default");
    ssel = 1;
    cfg(0, 1, 1);
    meas(256, 1, ex(256, 16, 1));
    req(2, 1);
    settle;
    meas(256, 1, ex(256, 16, 1));
    req(3, 0);
    settle;
    meas(256, 1, ex(256, 32, 1));
    ssel = 2;
    cfg(0, 1, 1);
    meas(2048, 1, ex(2048, 1024, 1));
    meas(256, 2, ex(256, 16, 1));
    fsel = 1;
    cfg(0, 1, 1);
    meas(256, 2, ex(256, 4, 2));
    report_and_stop;
end
endmodule // reset_and_clock_control_bench
